// ===== verilog/arc_pkg.sv
// Shared constants and types for the alarm relay output controller.
package arc_pkg;
  localparam int          NUM_RELAY      = 4;
  localparam int          NUM_BUZ        = 3;
  localparam int          DLY_W          = 6;
  localparam int          DLY_MAX_MIN    = 60;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          TICK_MS        = 100;
  localparam int          TICK_CYCLES    = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          TICKS_PER_SEC  = 10;
  localparam int          SECS_PER_MIN   = 60;
  localparam int          BL_AUTO_SEC    = 10;
  localparam int          BL_TICKS       = BL_AUTO_SEC * TICKS_PER_SEC;
  localparam int          PAT_PERIOD     = 20;
  localparam int          PAT_HALF       = 10;
  localparam logic [4:0]  TAP1_END       = 5'h02;
  localparam logic [4:0]  TAP2_BEG       = 5'h04;
  localparam logic [4:0]  TAP2_END       = 5'h06;
  localparam logic [7:0]  ADDR_RELAY0    = 8'h00;
  localparam logic [7:0]  ADDR_OUTCFG    = 8'h10;
  localparam logic [7:0]  ADDR_CMD       = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h20;
  localparam int          RC_ON_LSB      = 0;
  localparam int          RC_OFF_LSB     = 8;
  localparam int          RC_EN          = 16;
  localparam int          RC_NE          = 17;
  localparam int          RC_LATCH       = 18;
  localparam int          RC_BSTYLE      = 19;
  localparam int          RC_FAULT       = 20;
  localparam int          OC_BUZ_LSB     = 0;
  localparam int          OC_STROBE      = 3;
  localparam int          OC_BL_LSB      = 4;
  localparam int          CMD_LATCH_RST  = 0;
  localparam int          CMD_HUSH       = 1;
  localparam int          CMD_UNHUSH     = 2;
  localparam int          IN_W           = 14;
  typedef enum logic [1:0] {BL_OFF, BL_ON, BL_AUTO} arc_bl_mode_t;
  localparam arc_bl_mode_t BL_RESET      = BL_AUTO;
  localparam logic [7:0]  IRQ_MASK_RESET = 8'h00;
endpackage

// ===== verilog/arc_tick_if.sv
// Timebase ticks and buzzer cadence signals shared between modules.
interface arc_tick_if;
  logic tenthTick;
  logic secTick;
  logic minTick;
  logic blink;
  logic dblTap;
  modport src (output tenthTick, output secTick, output minTick);
  modport pat (input tenthTick, output blink, output dblTap);
  modport usr (input tenthTick, input secTick, input minTick,
               input blink, input dblTap);
endinterface

// ===== verilog/arc_timebase.sv
// Prescaler producing tenth-second, second and minute tick pulses.
module arc_timebase
  import arc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic   clock,
  input wire logic   rst_n,
  arc_tick_if.src    tk
);
  logic [31:0] divCnt_q;
  logic [3:0]  tenthCnt_q;
  logic [5:0]  secCnt_q;
  logic        tenth_q;
  logic        sec_q;
  logic        min_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      divCnt_q   <= 32'h0000_0000;
      tenthCnt_q <= 4'h0;
      secCnt_q   <= 6'h00;
      tenth_q    <= 1'b0;
      sec_q      <= 1'b0;
      min_q      <= 1'b0;
    end else begin
      tenth_q <= 1'b0;
      sec_q   <= 1'b0;
      min_q   <= 1'b0;
      if (divCnt_q == 32'(TICK_DIV - 1)) begin
        divCnt_q <= 32'h0000_0000;
        tenth_q  <= 1'b1;
        if (tenthCnt_q == 4'(TICKS_PER_SEC - 1)) begin
          tenthCnt_q <= 4'h0;
          sec_q      <= 1'b1;
          if (secCnt_q == 6'(SECS_PER_MIN - 1)) begin
            secCnt_q <= 6'h00;
            min_q    <= 1'b1;
          end else begin
            secCnt_q <= secCnt_q + 6'h01;
          end
        end else begin
          tenthCnt_q <= tenthCnt_q + 4'h1;
        end
      end else begin
        divCnt_q <= divCnt_q + 32'h0000_0001;
      end
    end
  end

  assign tk.tenthTick = tenth_q;
  assign tk.secTick   = sec_q;
  assign tk.minTick   = min_q;
endmodule

// ===== verilog/arc_pattern.sv
// Buzzer cadence generator for the blinking and double-tap patterns.
module arc_pattern
  import arc_pkg::*;
(
  input wire logic   clock,
  input wire logic   rst_n,
  arc_tick_if.pat    tk
);
  logic [4:0] phase_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_q <= 5'h00;
    end else if (tk.tenthTick) begin
      if (phase_q == 5'(PAT_PERIOD - 1)) begin
        phase_q <= 5'h00;
      end else begin
        phase_q <= phase_q + 5'h01;
      end
    end
  end

  assign tk.blink  = (phase_q < 5'(PAT_HALF));
  assign tk.dblTap = (phase_q < TAP1_END) ||
                     (phase_q >= TAP2_BEG && phase_q < TAP2_END);
endmodule

// ===== verilog/arc_relay_ctrl.sv
// Relay, buzzer, horn, strobe and backlight output control with APB.
// Notes on behaviour
// - Alarm must persist for the relay's on delay, 0 to 60 minutes.
// - Non-alarm must persist for the relay's off delay before release.
// - Polarity bit selects normally energized coil; default de-energized.
// - Latching relay stays actuated after alarm clears until acknowledged.
// - Buzzer style relays switch off on hush; normal style ignores it.
// - A disabled relay always stays de-actuated; default disabled.
// - Fault actuation makes assigned sensor faults actuate the relay.
// - Horn is on while any buzzer output is actuated.
// - Buzzer one sounds continuously while actuated.
// - Buzzer two sounds with half on, half off cadence.
// - Buzzer three sounds a double-tap cadence.
// - Each buzzer and the strobe has its own enable.
// - Backlight off, on or auto; auto lights ten seconds per key.
// - After reset every input and output is disabled; the code resets the backlight mode to auto.
// - Latch reset releases only latched relays whose alarm cleared.
// - Relay indicator follows coil drive.
// - Unhush clears hush; output re-alarms after its on delay again.
//
// Local design decisions: the placing of the registers and register access over APB.
module arc_relay_ctrl
  import arc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_RELAY-1:0] alarmIn,
  input  wire logic [NUM_RELAY-1:0] faultIn,
  input  wire logic [NUM_BUZ-1:0]   buzzerReq,
  input  wire logic                 strobeReq,
  input  wire logic                 keyPress,
  input  wire logic                 ackKey,
  output logic      [NUM_RELAY-1:0] relayCoil,
  output logic      [NUM_RELAY-1:0] relayLed,
  output logic      [NUM_BUZ-1:0]   buzzerOut,
  output logic                      hornOut,
  output logic                      strobeOut,
  output logic                      backlightOut,
  output logic                      irq
);
  arc_tick_if tk ();

  arc_timebase #(
    .TICK_DIV (TICK_DIV)
  ) u_timebase (
    .clock (clock),
    .rst_n (rst_n),
    .tk    (tk)
  );

  arc_pattern u_pattern (
    .clock (clock),
    .rst_n (rst_n),
    .tk    (tk)
  );

  logic [IN_W-1:0]      syncA_q;
  logic [IN_W-1:0]      syncB_q;
  logic                 keyPrev_q;
  logic                 ackPrev_q;
  logic [NUM_RELAY-1:0] alarmS;
  logic [NUM_RELAY-1:0] faultS;
  logic [NUM_BUZ-1:0]   buzReqS;
  logic                 strobeS;
  logic                 keyS;
  logic                 ackS;

  // Two-flop synchronisers for all pin inputs.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA_q   <= '0;
      syncB_q   <= '0;
      keyPrev_q <= 1'b0;
      ackPrev_q <= 1'b0;
    end else begin
      syncA_q   <= {ackKey, keyPress, strobeReq, buzzerReq, faultIn,
                    alarmIn};
      syncB_q   <= syncA_q;
      keyPrev_q <= keyS;
      ackPrev_q <= ackS;
    end
  end

  assign alarmS  = syncB_q[3:0];
  assign faultS  = syncB_q[7:4];
  assign buzReqS = syncB_q[10:8];
  assign strobeS = syncB_q[11];
  assign keyS    = syncB_q[12];
  assign ackS    = syncB_q[13];

  logic [NUM_RELAY-1:0][DLY_W-1:0] onDly_q;
  logic [NUM_RELAY-1:0][DLY_W-1:0] offDly_q;
  logic [NUM_RELAY-1:0]            en_q;
  logic [NUM_RELAY-1:0]            normEn_q;
  logic [NUM_RELAY-1:0]            latch_q;
  logic [NUM_RELAY-1:0]            bStyle_q;
  logic [NUM_RELAY-1:0]            faultAct_q;
  logic [NUM_BUZ-1:0]              buzEn_q;
  logic                            strobeEn_q;
  arc_bl_mode_t                    blMode_q;
  logic [7:0]                      irqMask_q;
  logic [7:0]                      irqStat_q;
  logic [7:0]                      irqSeen_q;
  logic                            pready_q;
  logic [31:0]                     prdata_q;
  logic                            pslverr_q;
  logic                            accWr;
  logic                            accRd;
  logic                            setup;
  logic                            mapped;
  logic                            latchRstCmd;
  logic                            hushCmd;
  logic                            unhushCmd;
  logic [31:0]                     rdMux;
  logic [NUM_RELAY-1:0]            act_q;
  logic [NUM_RELAY-1:0]            actPrev_q;
  logic [NUM_RELAY-1:0]            hold_q;
  logic [NUM_RELAY-1:0]            hush_q;
  logic [NUM_RELAY-1:0]            actuated;
  logic [NUM_BUZ-1:0]              bHush_q;
  logic [NUM_BUZ-1:0]              buzActive;
  logic [7:0]                      blCnt_q;
  logic [7:0]                      events;

  assign setup  = psel & penable & ~pready_q;
  assign accWr  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign accRd  = psel & penable & pready_q & ~pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_IRQ_MASK);

  assign latchRstCmd = (accWr && paddr == ADDR_CMD && pwdata[CMD_LATCH_RST])
                       || (ackS && !ackPrev_q);
  assign hushCmd     = accWr && paddr == ADDR_CMD && pwdata[CMD_HUSH];
  assign unhushCmd   = accWr && paddr == ADDR_CMD && pwdata[CMD_UNHUSH];

  // One wait state: answer registered in the first access cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      if (setup) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr_q <= ~mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (paddr < ADDR_OUTCFG) begin
      rdMux[RC_ON_LSB +: DLY_W]  = onDly_q[paddr[3:2]];
      rdMux[RC_OFF_LSB +: DLY_W] = offDly_q[paddr[3:2]];
      rdMux[RC_EN]               = en_q[paddr[3:2]];
      rdMux[RC_NE]               = normEn_q[paddr[3:2]];
      rdMux[RC_LATCH]            = latch_q[paddr[3:2]];
      rdMux[RC_BSTYLE]           = bStyle_q[paddr[3:2]];
      rdMux[RC_FAULT]            = faultAct_q[paddr[3:2]];
    end else if (paddr == ADDR_OUTCFG) begin
      rdMux[OC_BUZ_LSB +: NUM_BUZ] = buzEn_q;
      rdMux[OC_STROBE]             = strobeEn_q;
      rdMux[OC_BL_LSB +: 2]        = blMode_q;
    end else if (paddr == ADDR_STATUS) begin
      rdMux[20:0] = {backlightOut, hornOut, buzActive, hush_q, hold_q,
                     relayCoil, actuated};
    end else if (paddr == ADDR_IRQ_STAT) begin
      rdMux[7:0] = irqStat_q;
    end else if (paddr == ADDR_IRQ_MASK) begin
      rdMux[7:0] = irqMask_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      onDly_q    <= '0;
      offDly_q   <= '0;
      en_q       <= '0;
      normEn_q   <= '0;
      latch_q    <= '0;
      bStyle_q   <= '0;
      faultAct_q <= '0;
      buzEn_q    <= '0;
      strobeEn_q <= 1'b0;
      blMode_q   <= BL_RESET;
      irqMask_q  <= IRQ_MASK_RESET;
    end else if (accWr) begin
      if (paddr < ADDR_OUTCFG) begin
        onDly_q[paddr[3:2]]    <= pwdata[RC_ON_LSB +: DLY_W];
        offDly_q[paddr[3:2]]   <= pwdata[RC_OFF_LSB +: DLY_W];
        en_q[paddr[3:2]]       <= pwdata[RC_EN];
        normEn_q[paddr[3:2]]   <= pwdata[RC_NE];
        latch_q[paddr[3:2]]    <= pwdata[RC_LATCH];
        bStyle_q[paddr[3:2]]   <= pwdata[RC_BSTYLE];
        faultAct_q[paddr[3:2]] <= pwdata[RC_FAULT];
      end else if (paddr == ADDR_OUTCFG) begin
        buzEn_q    <= pwdata[OC_BUZ_LSB +: NUM_BUZ];
        strobeEn_q <= pwdata[OC_STROBE];
        if (pwdata[OC_BL_LSB +: 2] != 2'h3) begin
          blMode_q <= arc_bl_mode_t'(pwdata[OC_BL_LSB +: 2]);
        end
      end else if (paddr == ADDR_IRQ_MASK) begin
        irqMask_q <= pwdata[7:0];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_RELAY; i++) begin : g_relay
      logic [DLY_W-1:0] cnt_q;
      logic [DLY_W-1:0] onLim;
      logic [DLY_W-1:0] offLim;
      logic             cond;

      assign onLim  = (onDly_q[i] > DLY_W'(DLY_MAX_MIN)) ?
                      DLY_W'(DLY_MAX_MIN) : onDly_q[i];
      assign offLim = (offDly_q[i] > DLY_W'(DLY_MAX_MIN)) ?
                      DLY_W'(DLY_MAX_MIN) : offDly_q[i];
      // Faults count as alarm when selected.
      assign cond   = alarmS[i] | (faultAct_q[i] & faultS[i]);

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          act_q[i]  <= 1'b0;
          hold_q[i] <= 1'b0;
          hush_q[i] <= 1'b0;
          cnt_q     <= '0;
        end else if (!en_q[i]) begin
          act_q[i]  <= 1'b0;
          hold_q[i] <= 1'b0;
          hush_q[i] <= 1'b0;
          cnt_q     <= '0;
        end else if (unhushCmd && hush_q[i]) begin
          hush_q[i] <= 1'b0;
          act_q[i]  <= 1'b0;
          cnt_q     <= '0;
        // Release only latched relays with alarm gone.
        end else if (latchRstCmd && hold_q[i] && !cond) begin
          hold_q[i] <= 1'b0;
          act_q[i]  <= 1'b0;
          hush_q[i] <= 1'b0;
          cnt_q     <= '0;
        end else begin
          if (latch_q[i] && act_q[i]) begin
            hold_q[i] <= 1'b1;
          end
          if (hushCmd && bStyle_q[i] && act_q[i]) begin
            hush_q[i] <= 1'b1;
          end
          if (cond == act_q[i] || (act_q[i] && (hold_q[i] || latch_q[i])))
          begin
            cnt_q <= '0;
          end else if (cnt_q >= (cond ? onLim : offLim)) begin
            act_q[i] <= cond;
            cnt_q    <= '0;
            if (!cond) begin
              hush_q[i] <= 1'b0;
            end
          end else if (tk.minTick) begin
            cnt_q <= cnt_q + DLY_W'(1);
          end
        end
      end

      assign actuated[i] = act_q[i] & ~hush_q[i];
    end
  endgenerate

  genvar j;
  generate
    for (j = 0; j < NUM_BUZ; j++) begin : g_buz
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          bHush_q[j] <= 1'b0;
        end else if (unhushCmd || !buzReqS[j] || !buzEn_q[j]) begin
          bHush_q[j] <= 1'b0;
        end else if (hushCmd) begin
          bHush_q[j] <= 1'b1;
        end
      end
      // Each buzzer gated by its own enable.
      assign buzActive[j] = buzEn_q[j] & buzReqS[j] & ~bHush_q[j];
    end
  endgenerate

  // Auto backlight retriggered by each key press.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blCnt_q <= 8'h00;
    end else if (keyS && !keyPrev_q) begin
      blCnt_q <= 8'(BL_TICKS);
    end else if (tk.tenthTick && blCnt_q != 8'h00) begin
      blCnt_q <= blCnt_q - 8'h01;
    end
  end

  assign events = {actPrev_q & ~actuated, actuated & ~actPrev_q};

  // Sticky events; a set in the clearing cycle wins.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      actPrev_q <= '0;
      irqStat_q <= 8'h00;
      irqSeen_q <= 8'h00;
    end else begin
      actPrev_q <= actuated;
      if (setup && paddr == ADDR_IRQ_STAT) begin
        irqSeen_q <= irqStat_q;
      end
      if (accRd && paddr == ADDR_IRQ_STAT) begin
        irqStat_q <= (irqStat_q & ~irqSeen_q) | events;
      end else begin
        irqStat_q <= irqStat_q | events;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      relayCoil    <= '0;
      relayLed     <= '0;
      buzzerOut    <= '0;
      hornOut      <= 1'b0;
      strobeOut    <= 1'b0;
      backlightOut <= 1'b0;
      irq          <= 1'b0;
    end else begin
      relayCoil    <= actuated ^ normEn_q;
      relayLed     <= actuated ^ normEn_q;
      buzzerOut    <= {buzActive[2] & tk.dblTap, buzActive[1] & tk.blink,
                       buzActive[0]};
      hornOut      <= |buzActive;
      strobeOut    <= strobeEn_q & strobeS;
      backlightOut <= (blMode_q == BL_ON) ||
                      (blMode_q == BL_AUTO && blCnt_q != 8'h00);
      irq          <= |(irqStat_q & irqMask_q);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ===== test/arc_relay_ctrl_sva.sv
// Concurrent checks on the relay controller's bus and output ports.
module arc_relay_ctrl_sva
  import arc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_RELAY-1:0] relayCoil,
  input wire logic [NUM_RELAY-1:0] relayLed,
  input wire logic [NUM_BUZ-1:0]   buzzerOut,
  input wire logic                 hornOut,
  input wire logic                 strobeOut,
  input wire logic                 backlightOut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire logic badAddr = paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'h0;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  property p_answer;
    s_setup ##1 s_wait |=> pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_nospur;
    pready |-> psel && penable;
  endproperty
  property p_errok;
    pslverr |-> pready;
  endproperty
  property p_unmap;
    s_wait ##0 badAddr |=> pslverr;
  endproperty
  property p_unmap_rd;
    s_wait ##0 (badAddr && !pwrite) |=> prdata == 32'h0000_0000;
  endproperty
  property p_mapped;
    pready && !badAddr |-> !pslverr;
  endproperty
  property p_led;
    relayLed == relayCoil;
  endproperty
  property p_horn_on;
    $rose(|buzzerOut) |-> ##[0:2] hornOut;
  endproperty
  property p_horn_off;
    !hornOut [*3] |-> buzzerOut == '0;
  endproperty
  property p_rst;
    $rose(rst_n) |-> relayCoil == '0 && buzzerOut == '0 && !hornOut
      && !strobeOut && !backlightOut && !pready;
  endproperty
  a_answer:   assert property (p_answer) else $error("late bus answer");
  a_one:      assert property (p_one) else $error("long ready");
  a_nospur:   assert property (p_nospur) else $error("stray ready");
  a_errok:    assert property (p_errok) else $error("error without ready");
  a_unmap:    assert property (p_unmap) else $error("no bus error");
  a_unmap_rd: assert property (p_unmap_rd) else $error("error data");
  a_mapped:   assert property (p_mapped) else $error("false bus error");
  a_led:      assert property (p_led) else $error("led differs");
  a_horn_on:  assert property (p_horn_on) else $error("horn late");
  a_horn_off: assert property (p_horn_off) else $error("buzz no horn");
  a_rst:      assert property (p_rst) else $error("reset outputs");
endmodule

bind arc_relay_ctrl arc_relay_ctrl_sva #(.TICK_DIV(TICK_DIV)) u_sva (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .relayCoil(relayCoil), .relayLed(relayLed),
  .buzzerOut(buzzerOut), .hornOut(hornOut), .strobeOut(strobeOut),
  .backlightOut(backlightOut));

// ===== test/arc_relay_ctrl_bench.sv
// Self-checking bench for the alarm relay output controller.
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end
module arc_relay_ctrl_bench
  import arc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, hornOut, strobeOut, backlightOut, irq;
  logic [3:0]  alarmIn = 4'h0, faultIn = 4'h0, relayCoil, relayLed;
  logic [2:0]  buzzerReq = 3'h0, buzzerOut;
  logic        strobeReq = 1'b0, keyPress = 1'b0, ackKey = 1'b0;
  int          num_errors = 0, n_checks = 0, n, c1, c2, c3, ch;
  wire logic [15:0] allOut = {relayCoil, relayLed, buzzerOut, hornOut,
                              strobeOut, backlightOut, irq, 1'b0};
  arc_relay_ctrl #(.TICK_DIV(4)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarmIn(alarmIn),
    .faultIn(faultIn), .buzzerReq(buzzerReq), .strobeReq(strobeReq),
    .keyPress(keyPress), .ackKey(ackKey), .relayCoil(relayCoil),
    .relayLed(relayLed), .buzzerOut(buzzerOut), .hornOut(hornOut),
    .strobeOut(strobeOut), .backlightOut(backlightOut), .irq(irq));
  always #25 clock = ~clock;
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic setA(input logic [3:0] v);
    @(posedge clock);
    alarmIn <= v;
  endtask
  task automatic tap();
    @(posedge clock);
    keyPress <= 1'b1;
    @(posedge clock);
    keyPress <= 1'b0;
  endtask
  function automatic logic [31:0] rc(logic [4:0] f, logic [5:0] on,
                                     logic [5:0] off);
    return {11'h000, f, 2'h0, off, 2'h0, on};
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wt(0);
    `CHK("outs", 16'h0000, allOut)
    setA(4'hF);
    faultIn <= 4'hF;
    wt(8);
    `CHK("disabled", 4'h0, relayCoil)
    rdc("relay0", ADDR_RELAY0, 32'h0);
    rdc("outcfg", ADDR_OUTCFG, 32'h20);
    rdc("mask", ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {rerr, rdat})
    faultIn <= 4'h0;
    wr(ADDR_RELAY0 + 8'h04, rc(5'h03, 6'h00, 6'h00));
    wt(8);
    `CHK("energized", 1'b0, relayCoil[1])
    setA(4'h0);
    wt(8);
    `CHK("energized", 4'h2, relayCoil)
    `CHK("led", 4'h2, relayLed)
    wr(ADDR_RELAY0 + 8'h04, 32'h0);
    wt(8);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_RELAY0, rc(5'h01, 6'h00, 6'h00));
    setA(4'h1);
    wt(8);
    `CHK("coil", 4'h1, relayCoil)
    `CHK("irq", 1'b1, irq)
    rdc("stat", ADDR_IRQ_STAT, 32'h1);
    wt(1);
    `CHK("irq", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h0);
    setA(4'h0);
    wt(8);
    `CHK("coil", 4'h0, relayCoil)
    `CHK("irq", 1'b0, irq)
    rdc("stat", ADDR_IRQ_STAT, 32'h10);
    wr(ADDR_RELAY0, rc(5'h05, 6'h00, 6'h00));
    setA(4'h1);
    wt(8);
    setA(4'h0);
    wt(8);
    `CHK("latched", 4'h1, relayCoil)
    setA(4'h1);
    wr(ADDR_CMD, 32'h1);
    wt(8);
    `CHK("latched", 4'h1, relayCoil)
    setA(4'h0);
    wt(8);
    wr(ADDR_CMD, 32'h1);
    wt(8);
    `CHK("released", 4'h0, relayCoil)
    setA(4'h1);
    wt(8);
    setA(4'h0);
    wt(8);
    @(posedge clock);
    ackKey <= 1'b1;
    wt(8);
    `CHK("acked", 4'h0, relayCoil)
    @(posedge clock);
    ackKey <= 1'b0;
    wr(ADDR_RELAY0 + 8'h08, rc(5'h09, 6'h00, 6'h00));
    wr(ADDR_RELAY0 + 8'h0C, rc(5'h01, 6'h00, 6'h00));
    setA(4'hC);
    wt(8);
    `CHK("style", 4'hC, relayCoil)
    wr(ADDR_CMD, 32'h2);
    wt(8);
    `CHK("hush", 4'h8, relayCoil)
    wr(ADDR_CMD, 32'h4);
    wt(8);
    `CHK("unhush", 4'hC, relayCoil)
    wr(ADDR_RELAY0 + 8'h0C, rc(5'h11, 6'h00, 6'h00));
    setA(4'h0);
    faultIn <= 4'hC;
    wt(8);
    `CHK("fault", 4'h8, relayCoil)
    @(posedge clock);
    faultIn <= 4'h0;
    wr(ADDR_RELAY0, rc(5'h01, 6'h02, 6'h02));
    setA(4'h1);
    wt(2300);
    `CHK("ondelay", 1'b0, relayCoil[0])
    setA(4'h0);
    wt(20);
    setA(4'h1);
    wt(2300);
    `CHK("cancel", 1'b0, relayCoil[0])
    n = 0;
    while (relayCoil[0] !== 1'b1 && n < 2600) begin
      @(negedge clock);
      n++;
    end
    `CHK("ondelay", 1'b1, relayCoil[0])
    setA(4'h0);
    wt(100);
    `CHK("offdelay", 1'b1, relayCoil[0])
    wr(ADDR_OUTCFG, 32'h27);
    buzzerReq <= 3'h7;
    strobeReq <= 1'b1;
    wt(8);
    c1 = 0;
    c2 = 0;
    c3 = 0;
    ch = 0;
    repeat (800) begin
      @(negedge clock);
      c1 += int'(buzzerOut[0] === 1'b1);
      c2 += int'(buzzerOut[1] === 1'b1);
      c3 += int'(buzzerOut[2] === 1'b1);
      ch += int'(hornOut === 1'b1);
    end
    `CHK("buzzer1", 800, c1)
    `CHK("buzzer2", 1'b1, (c2 > 396 && c2 < 404))
    `CHK("buzzer3", 1'b1, (c3 > 156 && c3 < 164))
    `CHK("horn", 800, ch)
    `CHK("strobe", 1'b0, strobeOut)
    wr(ADDR_OUTCFG, 32'h29);
    wt(8);
    `CHK("separate", 5'h07, {buzzerOut, hornOut, strobeOut})
    @(posedge clock);
    buzzerReq <= 3'h0;
    wt(8);
    `CHK("horn", 1'b0, hornOut)
    tap();
    wt(20);
    `CHK("bl", 1'b1, backlightOut)
    wt(300);
    tap();
    wt(300);
    `CHK("bl", 1'b1, backlightOut)
    wt(150);
    `CHK("bl", 1'b0, backlightOut)
    wr(ADDR_OUTCFG, 32'h10);
    wt(8);
    `CHK("bl", 1'b1, backlightOut)
    wr(ADDR_OUTCFG, 32'h00);
    tap();
    wt(20);
    `CHK("bl", 1'b0, backlightOut)
    finish_test();
  end
endmodule
